// [include/gbtu_pkg.sv]
// Package of constants and types for the graphics block transfer unit
package gbtu_pkg;
  localparam int unsigned DW       = 32;
  localparam int unsigned AW       = 24;
  localparam int unsigned RAW      = 4;
  // Register indices on the plain register port
  localparam logic [3:0]  IDX_R0   = 4'h0;
  localparam logic [3:0]  IDX_R7   = 4'h7;
  localparam logic [3:0]  IDX_WID  = 4'h8;
  localparam logic [3:0]  IDX_FLG  = 4'h9;
  localparam logic [3:0]  IDX_CMD  = 4'hA;
  localparam logic [3:0]  IDX_STAT = 4'hB;
  localparam logic [31:0] REG_RST  = 32'h0000_0000;
  // Flag bit positions
  localparam int unsigned FLG_F    = 0;
  localparam int unsigned FLG_L    = 1;
  // Command word fields
  localparam int unsigned CMD_DA   = 17;
  localparam int unsigned CMD_AND  = 16;
  localparam int unsigned CMD_INV  = 15;
  localparam int unsigned CMD_OPH  = 13;
  localparam int unsigned CMD_OPL  = 10;
  localparam int unsigned CMD_IH   = 9;
  localparam int unsigned CMD_IL   = 8;
  localparam int unsigned CMD_OPT  = 8;
  // Command class in the low byte
  localparam logic [7:0]  CLS_BB   = 8'h0E;
  localparam logic [7:0]  CLS_WT   = 8'h01;
  localparam logic [7:0]  CLS_XB   = 8'h02;
  localparam logic [7:0]  CLS_PF   = 8'h03;
  localparam logic [7:0]  CLS_TB   = 8'h04;
  // Block operation codes and their i field
  localparam logic [3:0]  OP_AND   = 4'hA;
  localparam logic [3:0]  OP_OR    = 4'h6;
  localparam logic [3:0]  OP_XOR   = 4'hE;
  localparam logic [3:0]  OP_FOR   = 4'hC;
  localparam logic [3:0]  OP_COPY  = 4'h4;
  localparam logic [1:0]  I_AND    = 2'h3;
  localparam logic [1:0]  I_OTHER  = 2'h1;
  // Word step in bytes, word mask and word width in bits
  localparam logic [31:0] WSTEP    = 32'h0000_0002;
  localparam logic [15:0] ONES16   = 16'hFFFF;
  localparam logic [4:0]  WBITS    = 5'h10;

  typedef enum logic [4:0] {
    ST_IDLE, ST_BB_LINE, ST_BB_RSRC, ST_BB_RDST, ST_BB_WDST,
    ST_WT_RSRC, ST_WT_RDST, ST_WT_WDST,
    ST_XB_LINE, ST_XB_PRE, ST_XB_RSRC, ST_XB_RDST, ST_XB_WDST,
    ST_PF_WR, ST_TB_CHK, ST_TB_RD
  } gbtu_state_t;

  typedef struct packed {
    logic          rd;
    logic          wr;
    logic          ext;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } gbtu_mreq_t;
endpackage : gbtu_pkg

// [src/gbtu_unit.sv]
// Graphics block transfer unit: raster ops, fills and bit-run test
// Behaviour
// - Five block ops: AND, OR, XOR, fast OR, copy
// - Operands from R0-R7, width from stack (here the width register at IDX_WID)
// - Width counts source words per line
// - Horizontal by option, vertical by warp sign
// - Fast OR: true source, increasing only
// - Masks apply relative to source words
// - Encoding: D, X upper byte, inverse bit 15
// - Op and i field decode table
// - Word transfer ORs, stores, pointers plus two
// - Source word shifted up by shift count
// - Assisted: source read, dest read, write
// - Assisted: bytes, lines, signed increment, temp
// - Extra preload read unless low flag
// - Assisted: pointers past end plus warps
// - Fill stores pattern count times, steps
// - Fill ends: count zero, last address
// - Run test counts matching bits upward
// - Run test updates offset and result only
// - Found flag is completing bit value
// - Low flag when found or count reached, clear at offset limit
// - Zero mask bits keep destination bits
//
// Chosen here: the register offsets and the plain strobed port.
module gbtu_unit (
  input  wire logic                   i_clk,
  input  wire logic                   i_reset_n,
  input  wire logic [gbtu_pkg::RAW-1:0] i_addr,
  input  wire logic [gbtu_pkg::DW-1:0]  i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [gbtu_pkg::DW-1:0]  o_rdata,
  output gbtu_pkg::gbtu_mreq_t        o_mem,
  input  wire logic [gbtu_pkg::DW-1:0]  i_mem_rdata,
  input  wire logic                   i_mem_ack,
  output logic                        o_busy,
  output logic                        o_done
);
  import gbtu_pkg::*;

  gbtu_state_t st_r;
  logic [DW-1:0] r_r [8];
  logic [DW-1:0] wid_r;
  logic [DW-1:0] cnt_r;
  logic [23:0]   cmd_r;
  logic          f_r;
  logic          l_r;
  logic          first_r;
  logic [15:0]   prev_r;
  logic [15:0]   al_r;
  logic [15:0]   msk_r;
  gbtu_mreq_t    mreq_r;
  logic          done_r;

  // Combined op for block ops; zero mask bits keep destination
  function automatic logic [15:0] bb_res(input logic [3:0] op, input logic [15:0] s,
                                         input logic [15:0] d, input logic [15:0] m);
    logic [15:0] v;
    v = s;
    case (op)
      OP_AND:  v = s & d;
      OP_OR:   v = s | d;
      OP_FOR:  v = s | d;
      OP_XOR:  v = s ^ d;
      OP_COPY: v = s;
      default: v = d;
    endcase
    return (d & ~m) | (v & m);
  endfunction : bb_res

  // Op and i pairs that are legal block ops
  function automatic logic bb_legal(input logic [23:0] c);
    logic [3:0] op;
    logic [1:0] iv;
    op = c[CMD_OPH:CMD_OPL];
    iv = c[CMD_IH:CMD_IL];
    case (op)
      OP_AND:                  return iv == I_AND && c[CMD_AND];
      OP_OR, OP_XOR, OP_COPY:  return iv == I_OTHER && !c[CMD_AND];
      OP_FOR:                  return iv == I_OTHER && !c[CMD_AND];
      default:                 return 1'b0;
    endcase
  endfunction : bb_legal

  function automatic logic [AW-1:0] to_addr(input logic [DW-1:0] v);
    return v[AW-1:0];
  endfunction : to_addr

  logic          is_for;
  logic          bb_inv;
  logic [DW-1:0] bb_step;
  logic [3:0]    sh;
  logic [15:0]   src_w;
  logic [31:0]   al_full;
  logic [15:0]   msk_nxt;
  logic [DW-1:0] xb_abs;
  logic [DW-1:0] xb_left;
  logic [DW-1:0] tb_byte;
  logic          tb_bit;
  logic          start;

  // Fast OR forces true source and increasing direction
  assign is_for  = cmd_r[CMD_OPH:CMD_OPL] == OP_FOR;
  assign bb_inv  = cmd_r[CMD_INV] && !is_for;
  assign bb_step = (cmd_r[CMD_DA] && !is_for) ? -WSTEP : WSTEP;
  assign sh      = r_r[2][3:0];
  assign src_w   = i_mem_rdata[15:0] ^ (bb_inv ? ONES16 : 16'h0000);
  // Carry bits of the previous source word fill the low end
  assign al_full = ({16'h0000, src_w} << sh) |
                   ({16'h0000, prev_r} >> (WBITS - {1'b0, sh}));
  // First mask on first source word, second on last
  assign msk_nxt = (first_r ? r_r[4][15:0] : ONES16) &
                   ((cnt_r == 32'd1) ? r_r[5][15:0] : ONES16);
  assign xb_abs  = r_r[4][DW-1] ? -r_r[4] : r_r[4];
  assign xb_left = r_r[5] - xb_abs;
  assign tb_byte = r_r[0] + {{3{r_r[1][DW-1]}}, r_r[1][DW-1:3]};
  assign tb_bit  = i_mem_rdata[r_r[1][2:0]];
  assign start   = i_wr && i_addr == IDX_CMD && st_r == ST_IDLE;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_r    <= ST_IDLE;
      for (int k = 0; k < 8; k++) begin
        r_r[k] <= REG_RST;
      end
      wid_r   <= REG_RST;
      cnt_r   <= REG_RST;
      cmd_r   <= 24'h00_0000;
      f_r     <= 1'b0;
      l_r     <= 1'b0;
      first_r <= 1'b0;
      prev_r  <= 16'h0000;
      al_r    <= 16'h0000;
      msk_r   <= 16'h0000;
      mreq_r  <= '0;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (i_wr && i_addr <= IDX_R7) begin
            r_r[i_addr[2:0]] <= i_wdata;
          end
          if (i_wr && i_addr == IDX_WID) begin
            wid_r <= i_wdata;
          end
          if (i_wr && i_addr == IDX_FLG) begin
            f_r <= i_wdata[FLG_F];
            l_r <= i_wdata[FLG_L];
          end
          if (start) begin
            cmd_r <= i_wdata[23:0];
            case (i_wdata[7:0])
              CLS_BB: begin
                if (bb_legal(i_wdata[23:0])) begin
                  st_r <= ST_BB_LINE;
                end else begin
                  done_r <= 1'b1;
                end
              end
              CLS_WT: begin
                mreq_r <= '{rd: 1'b1, wr: 1'b0, ext: 1'b0,
                            addr: to_addr(r_r[0]), wdata: '0};
                st_r   <= ST_WT_RSRC;
              end
              CLS_XB:  st_r <= ST_XB_LINE;
              CLS_PF:  st_r <= ST_PF_WR;
              CLS_TB: begin
                r_r[2] <= REG_RST;
                st_r   <= ST_TB_CHK;
              end
              default: done_r <= 1'b1;
            endcase
          end
        end
        // Outer loop: one pass per line, height counts down
        ST_BB_LINE: begin
          if (r_r[3] == REG_RST || wid_r == REG_RST) begin
            st_r   <= ST_IDLE;
            done_r <= 1'b1;
          end else begin
            cnt_r   <= wid_r;
            first_r <= 1'b1;
            prev_r  <= 16'h0000;
            mreq_r  <= '{rd: 1'b1, wr: 1'b0, ext: 1'b0,
                         addr: to_addr(r_r[0]), wdata: '0};
            st_r    <= ST_BB_RSRC;
          end
        end
        ST_BB_RSRC: begin
          if (i_mem_ack) begin
            prev_r <= src_w;
            al_r   <= al_full[15:0];
            msk_r  <= msk_nxt;
            mreq_r <= '{rd: 1'b1, wr: 1'b0, ext: 1'b0,
                        addr: to_addr(r_r[1]), wdata: '0};
            st_r   <= ST_BB_RDST;
          end
        end
        ST_BB_RDST: begin
          if (i_mem_ack) begin
            mreq_r <= '{rd: 1'b0, wr: 1'b1, ext: 1'b0, addr: to_addr(r_r[1]),
                        wdata: {16'h0000, bb_res(cmd_r[CMD_OPH:CMD_OPL], al_r,
                                                 i_mem_rdata[15:0], msk_r)}};
            st_r   <= ST_BB_WDST;
          end
        end
        ST_BB_WDST: begin
          if (i_mem_ack) begin
            first_r <= 1'b0;
            cnt_r   <= cnt_r - 32'd1;
            if (cnt_r == 32'd1) begin
              // Signed warps pick up or down for the next line
              r_r[0] <= r_r[0] + bb_step + r_r[6];
              r_r[1] <= r_r[1] + bb_step + r_r[7];
              r_r[3] <= r_r[3] - 32'd1;
              mreq_r <= '0;
              st_r   <= ST_BB_LINE;
            end else begin
              r_r[0] <= r_r[0] + bb_step;
              r_r[1] <= r_r[1] + bb_step;
              mreq_r <= '{rd: 1'b1, wr: 1'b0, ext: 1'b0,
                          addr: to_addr(r_r[0] + bb_step), wdata: '0};
              st_r   <= ST_BB_RSRC;
            end
          end
        end
        ST_WT_RSRC: begin
          if (i_mem_ack) begin
            al_r   <= i_mem_rdata[15:0];
            mreq_r <= '{rd: 1'b1, wr: 1'b0, ext: 1'b0,
                        addr: to_addr(r_r[1]), wdata: '0};
            st_r   <= ST_WT_RDST;
          end
        end
        ST_WT_RDST: begin
          if (i_mem_ack) begin
            // No masking: source assumed clean
            mreq_r <= '{rd: 1'b0, wr: 1'b1, ext: 1'b0, addr: to_addr(r_r[1]),
                        wdata: i_mem_rdata | ({16'h0000, al_r} << sh)};
            st_r   <= ST_WT_WDST;
          end
        end
        ST_WT_WDST: begin
          if (i_mem_ack) begin
            r_r[0] <= r_r[0] + WSTEP;
            r_r[1] <= r_r[1] + WSTEP;
            mreq_r <= '0;
            done_r <= 1'b1;
            st_r   <= ST_IDLE;
          end
        end
        // External unit control is loaded by software beforehand
        ST_XB_LINE: begin
          if (r_r[3] == REG_RST || r_r[2] == REG_RST) begin
            done_r <= 1'b1;
            st_r   <= ST_IDLE;
          end else begin
            r_r[5] <= r_r[2];
            mreq_r <= '{rd: 1'b1, wr: 1'b0, ext: 1'b1,
                        addr: to_addr(r_r[0]), wdata: '0};
            st_r   <= l_r ? ST_XB_RSRC : ST_XB_PRE;
          end
        end
        ST_XB_PRE: begin
          if (i_mem_ack) begin
            r_r[0] <= r_r[0] + r_r[4];
            mreq_r <= '{rd: 1'b1, wr: 1'b0, ext: 1'b1,
                        addr: to_addr(r_r[0] + r_r[4]), wdata: '0};
            st_r   <= ST_XB_RSRC;
          end
        end
        ST_XB_RSRC: begin
          if (i_mem_ack) begin
            r_r[0] <= r_r[0] + r_r[4];
            mreq_r <= '{rd: 1'b1, wr: 1'b0, ext: 1'b1,
                        addr: to_addr(r_r[1]), wdata: '0};
            st_r   <= ST_XB_RDST;
          end
        end
        ST_XB_RDST: begin
          if (i_mem_ack) begin
            // Write data comes from the external unit
            mreq_r <= '{rd: 1'b0, wr: 1'b1, ext: 1'b1,
                        addr: to_addr(r_r[1]), wdata: '0};
            st_r   <= ST_XB_WDST;
          end
        end
        ST_XB_WDST: begin
          if (i_mem_ack) begin
            r_r[5] <= xb_left;
            if ($signed(xb_left) <= 0) begin
              r_r[0] <= r_r[0] + r_r[6];
              r_r[1] <= r_r[1] + r_r[4] + r_r[7];
              r_r[3] <= r_r[3] - 32'd1;
              mreq_r <= '0;
              st_r   <= ST_XB_LINE;
            end else begin
              r_r[1] <= r_r[1] + r_r[4];
              mreq_r <= '{rd: 1'b1, wr: 1'b0, ext: 1'b1,
                          addr: to_addr(r_r[0]), wdata: '0};
              st_r   <= ST_XB_RSRC;
            end
          end
        end
        // Write issued first, then the count steps
        ST_PF_WR: begin
          if (!mreq_r.wr) begin
            if (r_r[2] == REG_RST) begin
              done_r <= 1'b1;
              st_r   <= ST_IDLE;
            end else begin
              mreq_r <= '{rd: 1'b0, wr: 1'b1, ext: 1'b0,
                          addr: to_addr(r_r[0]), wdata: r_r[3]};
            end
          end else if (i_mem_ack) begin
            mreq_r <= '0;
            r_r[2] <= r_r[2] - 32'd1;
            if (r_r[2] != 32'd1) begin
              r_r[0] <= r_r[0] + r_r[1];
            end
          end
        end
        ST_TB_CHK: begin
          if (r_r[2] == r_r[3]) begin
            f_r    <= cmd_r[CMD_OPT];
            l_r    <= 1'b1;
            done_r <= 1'b1;
            st_r   <= ST_IDLE;
          end else if ($signed(r_r[1]) >= $signed(r_r[4])) begin
            f_r    <= cmd_r[CMD_OPT];
            l_r    <= 1'b0;
            done_r <= 1'b1;
            st_r   <= ST_IDLE;
          end else begin
            mreq_r <= '{rd: 1'b1, wr: 1'b0, ext: 1'b0,
                        addr: to_addr(tb_byte), wdata: '0};
            st_r   <= ST_TB_RD;
          end
        end
        // One byte read per bit: slow but simple
        ST_TB_RD: begin
          if (i_mem_ack) begin
            mreq_r <= '0;
            if (tb_bit == cmd_r[CMD_OPT]) begin
              r_r[1] <= r_r[1] + 32'd1;
              r_r[2] <= r_r[2] + 32'd1;
              st_r   <= ST_TB_CHK;
            end else begin
              f_r    <= tb_bit;
              l_r    <= 1'b1;
              done_r <= 1'b1;
              st_r   <= ST_IDLE;
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Read data valid the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rdata <= REG_RST;
    end else if (i_rd) begin
      if (i_addr <= IDX_R7) begin
        o_rdata <= r_r[i_addr[2:0]];
      end else if (i_addr == IDX_WID) begin
        o_rdata <= wid_r;
      end else if (i_addr == IDX_FLG) begin
        o_rdata <= {30'h0, l_r, f_r};
      end else if (i_addr == IDX_CMD) begin
        o_rdata <= {8'h00, cmd_r};
      end else if (i_addr == IDX_STAT) begin
        o_rdata <= {31'h0, st_r != ST_IDLE};
      end else begin
        o_rdata <= REG_RST;
      end
    end else begin
      o_rdata <= REG_RST;
    end
  end

  assign o_mem  = mreq_r;
  assign o_busy = st_r != ST_IDLE;
  assign o_done = done_r;
endmodule : gbtu_unit

// [verification/gbtu_unit_sva.sv]
// Port assertions for the graphics block transfer unit
module gbtu_unit_sva
  import gbtu_pkg::*;
(
  input wire logic                      i_clk,
  input wire logic                      i_reset_n,
  input wire logic [gbtu_pkg::RAW-1:0]  i_addr,
  input wire logic [gbtu_pkg::DW-1:0]   i_wdata,
  input wire logic                      i_wr,
  input wire logic                      i_rd,
  input wire logic [gbtu_pkg::DW-1:0]   o_rdata,
  input gbtu_pkg::gbtu_mreq_t           o_mem,
  input wire logic [gbtu_pkg::DW-1:0]   i_mem_rdata,
  input wire logic                      i_mem_ack,
  input wire logic                      o_busy,
  input wire logic                      o_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic last_rd_r;
  // Kind of the last finished bus cycle
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) last_rd_r <= 1'b0;
    else if (i_mem_ack) last_rd_r <= o_mem.rd;
  end
  a_rd_wr_excl: assert property (!(o_mem.rd && o_mem.wr))
    else $error("read and write at once");
  a_req_hold: assert property ((o_mem.rd || o_mem.wr) && !i_mem_ack |=> $stable(o_mem))
    else $error("request moved before ack");
  a_ext_wdata: assert property (o_mem.ext && o_mem.wr |-> o_mem.wdata == '0)
    else $error("assisted write drives data");
  a_ext_after_rd: assert property ($rose(o_mem.wr) && o_mem.ext |-> last_rd_r)
    else $error("assisted write without read");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done too long");
  a_done_idle: assert property (o_done |=> !o_busy && !o_mem.rd && !o_mem.wr)
    else $error("activity after done");
  a_idle_quiet: assert property (!o_busy |-> !o_mem.rd && !o_mem.wr)
    else $error("bus cycle while idle");
  a_cmd_starts: assert property (i_wr && i_addr == IDX_CMD && !o_busy
    |-> ##[1:2] (o_busy || o_done)) else $error("command not started");
  a_rdata_zero: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside slot");
  c_ext_wr: cover property (o_mem.ext && o_mem.wr && i_mem_ack);
  c_plain_wr: cover property (o_mem.wr && !o_mem.ext && i_mem_ack);
  c_done: cover property (o_done);
endmodule : gbtu_unit_sva

bind gbtu_unit gbtu_unit_sva u_gbtu_unit_sva (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mem(o_mem),
  .i_mem_rdata(i_mem_rdata), .i_mem_ack(i_mem_ack), .o_busy(o_busy), .o_done(o_done));

// [verification/gbtu_mem_model.sv]
// Frame buffer memory model with random answer delay
module gbtu_mem_model
  import gbtu_pkg::*;
(
  input wire logic                    i_clk,
  input gbtu_pkg::gbtu_mreq_t         i_mem,
  output logic [gbtu_pkg::DW-1:0]     o_rdata,
  output logic                        o_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DW-1:0] mem [int];
  int n_rd = 0, n_wr = 0, n_ext = 0, dly = 0;
  initial o_rdata = 32'h5A5A_A5A5;
  initial o_ack = 1'b0;
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    // Idle data toggles so stale data never looks valid
    o_rdata <= ~o_rdata;
    if ((i_mem.rd || i_mem.wr) && !o_ack) begin
      if (dly > 0) dly <= dly - 1;
      else begin
        o_ack <= 1'b1;
        dly <= $urandom_range(2, 0);
        n_ext <= n_ext + int'(i_mem.ext);
        if (i_mem.wr) begin
          n_wr <= n_wr + 1;
          mem[int'(i_mem.addr)] = i_mem.wdata;
        end else begin
          n_rd <= n_rd + 1;
          o_rdata <= mem.exists(int'(i_mem.addr)) ? mem[int'(i_mem.addr)] : 32'h5A5A_A5A5;
        end
      end
    end
  end
endmodule : gbtu_mem_model

// [verification/test_gbtu_unit.sv]
// Self-checking bench for the graphics block transfer unit
module test_gbtu_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import gbtu_pkg::*;
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic i_mem_ack, o_busy, o_done, ef, el, opt, da_b;
  logic [RAW-1:0] i_addr = '0;
  logic [DW-1:0] i_wdata = '0, o_rdata, i_mem_rdata, s, d, eo, ec;
  logic [DW-1:0] rv [8];
  logic [3:0] ops [5] = '{OP_AND, OP_OR, OP_XOR, OP_FOR, OP_COPY};
  logic [63:0] bits;
  gbtu_mreq_t o_mem;
  int n_mismatch = 0, num_checks = 0, cyc = 0, nr, nw, nx, inc, w, h;
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    // Far above the few thousand cycles the run needs
    if (cyc == 50000) begin
      n_mismatch++;
      summarize();
    end
  end
  gbtu_unit u_gbtu_unit (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mem(o_mem),
    .i_mem_rdata(i_mem_rdata), .i_mem_ack(i_mem_ack), .o_busy(o_busy), .o_done(o_done));
  gbtu_mem_model u_mem (.i_clk(i_clk), .i_mem(o_mem), .o_rdata(i_mem_rdata),
    .o_ack(i_mem_ack));
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] x);
    num_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk
  task automatic wreg(input logic [RAW-1:0] a, input logic [DW-1:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wreg
  task automatic rchk(input logic [RAW-1:0] a, input logic [DW-1:0] x);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, x);
  endtask : rchk
  task automatic load();
    for (int i = 0; i < 8; i++) wreg(RAW'(i), rv[i]);
    nr = u_mem.n_rd;
    nw = u_mem.n_wr;
    nx = u_mem.n_ext;
  endtask : load
  task automatic run(input logic [DW-1:0] cmd);
    int t = 0;
    wreg(IDX_CMD, cmd);
    // Refused commands pulse done at the edge that takes the write
    #1;
    while (o_done !== 1'b1 && t < 2000) begin
      @(posedge i_clk);
      #1 t++;
    end
    if (t >= 2000) chk(32'h1, 32'h0);
    @(posedge i_clk);
  endtask : run
  function automatic logic [15:0] bop(input logic [3:0] op, input logic inv,
                                      input logic [15:0] a, b, m);
    logic [15:0] x;
    x = inv ? ~a : a;
    case (op)
      OP_AND: x = x & b;
      OP_XOR: x = x ^ b;
      OP_COPY: x = x;
      default: x = x | b;
    endcase
    return (x & m) | (b & ~m);
  endfunction : bop
  function automatic logic [DW-1:0] bcmd(input logic [3:0] op, input logic da, x, inv);
    return {14'h0, da, x, inv, 1'b0, op, (op == OP_AND) ? I_AND : I_OTHER, CLS_BB};
  endfunction : bcmd
  function automatic void trun();
    eo = rv[1];
    ec = 0;
    ef = opt;
    el = 1'b1;
    while (ec != rv[3]) begin
      if ($signed(eo) >= $signed(rv[4])) begin
        el = 1'b0;
        break;
      end
      if (bits[eo[5:0]] != opt) begin
        ef = ~opt;
        break;
      end
      eo++;
      ec++;
    end
  endfunction : trun
  initial begin
    w = $urandom(60483);
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    for (int a = 0; a < 13; a++) rchk(RAW'(a), REG_RST);
    // Raster ops, true then inverted; pass 10 is a refused encoding
    // Fast OR passes set decreasing, pass 8 also inverse, which it ignores
    for (int j = 0; j < 11; j++) begin
      s = $urandom;
      d = $urandom;
      rv = '{32'h100, 32'h200, 32'h0, 32'h1, $urandom, $urandom, 32'h0, 32'h0};
      u_mem.mem[32'h100] = s;
      u_mem.mem[32'h200] = d;
      load();
      wreg(IDX_WID, 32'h1);
      da_b = j % 5 == 3 || s[31];
      run(bcmd(ops[j % 5], da_b, j % 5 == 0 && j < 10, j > 4));
      if (j == 10) chk(u_mem.mem[32'h200], d);
      else chk({16'h0, u_mem.mem[32'h200][15:0]}, {16'h0, bop(ops[j % 5],
        j > 4 && j % 5 != 3, s[15:0], d[15:0],
        rv[4][15:0] & rv[5][15:0])});
      rchk(4'h0, j == 10 ? 32'h100 : (da_b && j % 5 != 3) ? 32'hFE : 32'h102);
    end
    w = $urandom_range(3, 1);
    h = $urandom_range(3, 1);
    rv = '{32'h100, 32'h200, 32'h3, 32'(h), 32'hFFFF, 32'hFFFF, 32'h10, 32'h10};
    load();
    wreg(IDX_WID, 32'(w));
    run(bcmd(OP_COPY, 1'b0, 1'b0, 1'b0));
    chk(u_mem.n_wr - nw, w * h);
    // Shifted word OR, shift 0 up to 15
    for (int j = 0; j < 4; j++) begin
      s = $urandom;
      d = $urandom;
      rv = '{32'h300, 32'h400, 32'(j * 5), 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
      u_mem.mem[32'h300] = s;
      u_mem.mem[32'h400] = d;
      load();
      run({24'h0, CLS_WT});
      chk(u_mem.mem[32'h400], d | ({16'h0, s[15:0]} << (j * 5)));
      rchk(4'h0, 32'h302);
      rchk(4'h1, 32'h402);
    end
    for (int l = 1; l >= 0; l--) begin
      rv = '{32'h500, 32'h600, 32'h4, 32'h2, 32'h2, 32'h0, 32'h0, 32'h0};
      load();
      wreg(IDX_FLG, 32'(l) << FLG_L);  // aligned pointers, unit set up first
      run({24'h0, CLS_XB});
      chk(u_mem.n_rd - nr, 8 + 2 * (1 - l));
      chk(u_mem.n_wr - nw, 4);
      chk(u_mem.n_ext - nx, 12 + 2 * (1 - l));
      rchk(4'h1, 32'h608);
      rchk(4'h4, 32'h2);
      rchk(4'h0, l ? 32'h508 : 32'h50C);
    end
    for (int j = 0; j < 4; j++) begin
      inc = (j % 2 ? -1 : 1) * int'($urandom_range(4, 1));
      rv = '{32'h700, 32'(inc), $urandom_range(5, 1), $urandom, 32'h0, 32'h0, 32'h0, 32'h0};
      load();
      run({24'h0, CLS_PF});
      chk(u_mem.n_wr - nw, rv[2]);
      for (int k = 0; k < rv[2]; k++) chk(u_mem.mem[32'h700 + k * inc], rv[3]);
      rchk(4'h0, 32'h700 + (rv[2] - 1) * inc);
      rchk(4'h1, 32'(inc));
      rchk(4'h2, 32'h0);
      rchk(4'h3, rv[3]);
    end
    // Bit runs; the first starts already at the offset limit
    for (int j = 0; j < 8; j++) begin
      bits = {$urandom, $urandom};
      for (int k = 0; k < 8; k++) u_mem.mem[32'h800 + k] = {24'h0, bits[8 * k +: 8]};
      opt = j % 2;
      rv = '{32'h800, $urandom_range(40, 0), $urandom, $urandom_range(24, 0),
             $urandom_range(63, 0), 32'h0, 32'h0, 32'h0};
      if (j == 0) rv[4] = rv[1];
      load();
      trun();
      run({23'h0, opt, CLS_TB});
      rchk(4'h1, eo);
      rchk(4'h2, ec);
      rchk(IDX_FLG, {30'h0, el, ef});
      rchk(4'h4, rv[4]);
    end
    summarize();
  end
endmodule : test_gbtu_unit
